// File: verilog/osq_pkg.sv
// Shared constants and types of the oversampled output sequencer.
// Assumes a single 25 MHz clock domain and a synchronous active-low reset.
package osq_pkg;
   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int CLK_PERIOD_NS = 40;                      // Clock period
   localparam int US_NS         = 1000;                    // One microsecond
   localparam int MS_NS         = 1000000;                 // One millisecond
   localparam int US_CLK        = US_NS / CLK_PERIOD_NS;   // Cycles per microsecond
   localparam int MS_CLK        = MS_NS / CLK_PERIOD_NS;   // Cycles per millisecond
   localparam int WD_TIME_MS    = 100;                     // Watchdog timeout after reset
   localparam logic [15:0] WD_TIME_MS_RST = 16'(WD_TIME_MS); // Watchdog reset value

   // ***************************************************************
   // Register map and widths
   // ***************************************************************
   localparam logic [11:0] REG_ERR_CNT_OFS = 12'h30D;      // Frame sequence error count
   localparam logic [7:0]  ERR_CNT_RST     = 8'h00;        // Error count after reset
   localparam int SAMPLE_W = 16;                           // One sample word
   localparam int SEQ_W    = 16;                           // One channel sequence counter

   // ***************************************************************
   // Types
   // ***************************************************************
   typedef enum logic {OSQ_IDLE, OSQ_RUN} osq_blk_t;       // Block sequencing state

   typedef struct packed {
      logic [15:0]        cycle_us;                        // Bus cycle time in us
      logic [7:0]         factor;                          // Oversampling factor
      logic [7:0]         word_count;                      // Sample words per channel
      logic signed [15:0] shift_us;                        // Shift time in us
   } osq_cfg_t;
endpackage

// File: verilog/osq_sequencer.sv
// Sample FIFO and output sequencer of an oversampling analog output device.
// Assumes raw sync events, bus time and process data arrive synchronous to mclk.
`timescale 1ns/1ps

// ***************************************************************
// Sample FIFO
// ***************************************************************
module osq_fifo
   import osq_pkg::*;
#(
   parameter int W     = 32,                               // Word width
   parameter int DEPTH = 4                                 // Word count
) (
   input  wire logic         mclk,                         // Clock
   input  wire logic         rst_n,                        // Sync reset, low
   input  wire logic         in_valid,                     // Word offered
   output logic              in_ready,                     // Room for a word
   input  wire logic [W-1:0] in_data,                      // Word in
   output logic              out_valid,                    // Word available
   input  wire logic         out_ready,                    // Word taken
   output logic [W-1:0]      out_data                      // Word out
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;    // Pointer width
   localparam int CW = $clog2(DEPTH + 1);                  // Count width

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;                        // Storage
      logic [PW-1:0]           wp;                         // Write pointer
      logic [PW-1:0]           rp;                         // Read pointer
      logic [CW-1:0]           cnt;                        // Fill level
      logic                    rdy;                        // Not full
   } osq_fifo_st_t;

   osq_fifo_st_t st_r;                                     // State
   osq_fifo_st_t st_nxt;                                   // Next state

   assign in_ready  = st_r.rdy;
   assign out_valid = (st_r.cnt != '0);
   assign out_data  = st_r.mem[st_r.rp];

   // Push and pop, full stays honest through the registered ready
   always_comb begin
      st_nxt = st_r;
      if (in_valid && st_r.rdy) begin
         st_nxt.mem[st_r.wp] = in_data;
         st_nxt.wp = (st_r.wp == PW'(DEPTH - 1)) ? '0 : PW'(st_r.wp + 1'b1);
      end
      if (out_ready && out_valid) begin
         st_nxt.rp = (st_r.rp == PW'(DEPTH - 1)) ? '0 : PW'(st_r.rp + 1'b1);
      end
      st_nxt.cnt = CW'(st_r.cnt + CW'(in_valid && st_r.rdy) - CW'(out_ready && out_valid));
      st_nxt.rdy = (st_nxt.cnt != CW'(DEPTH));
   end

   // State register
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st_r     <= '0;
         st_r.rdy <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule

// ***************************************************************
// Sequencer top
// ***************************************************************
// Overview of operation
// - New block starts on every shifted block event
// - Sample period is cycle over oversampling factor
// - One conversion per sample tick, next sample
// - Word count mismatch: no output produced
// - Block and sample events delayed by shift
// - Sequence break adds one to error count
// - Watchdog enabled at reset, 100 ms
// - Data output; commit restarts watchdog
// - No fresh data: hold last value
// - Watchdog time zero disables watchdog
// - Supply low 32 bits of next block time
module osq_sequencer
   import osq_pkg::*;
#(
   parameter int NCH           = 2,                        // Output channels
   parameter int FIFO_DEPTH    = 4,                        // Sample FIFO depth
   parameter int SHIFT_BIAS_US = 20,                       // Delay added so negative shifts fit
   parameter int MS_CYCLES     = MS_CLK                    // Cycles per watchdog tick
) (
   input  wire logic                   mclk,               // Clock, 25 MHz
   input  wire logic                   rst_n,              // Sync reset, low
   input  wire logic                   sync1_raw,          // Unshifted block event pulse
   input  wire logic [31:0]            dc_time_lo,         // Local bus time, low 32 bits, ns
   input  wire osq_cfg_t               cfg,                // Cycle, factor, count, shift
   input  wire logic                   wd_cfg_wr,          // Load watchdog time
   input  wire logic [15:0]            wd_cfg_ms,          // Watchdog time in ms
   input  wire logic                   pd_valid,           // Sample vector offered
   output logic                        pd_ready,           // Sample vector accepted
   input  wire logic [NCH*SAMPLE_W-1:0] pd_data,           // One sample per channel
   input  wire logic                   pd_commit,          // Buffer access completed
   input  wire logic [NCH*SEQ_W-1:0]   pd_seq,             // Sequence counters
   input  wire logic                   reg_rd,             // Register read strobe
   input  wire logic [11:0]            reg_addr,           // Register offset
   output logic [7:0]                  reg_rdata,          // Register read data
   output logic                        dac_strobe,         // Conversion start
   output logic [NCH*SAMPLE_W-1:0]     dac_data,           // Converter codes
   output logic [31:0]                 next_block_start_time, // Next block time
   output logic [7:0]                  sample_index,       // Index in block
   output logic                        wd_expired          // Outputs forced to zero
);
   localparam int DW = NCH * SAMPLE_W;                     // Sample vector width

   typedef struct packed {
      logic [31:0]        dly_cnt;                         // Shift delay countdown
      logic               dly_busy;                        // Shifted event pending
      logic [31:0]        per_cnt;                         // Sample period countdown
      logic [7:0]         idx;                             // Sample index
      osq_blk_t           blk;                             // Block state
      logic               fresh;                           // Commit since last block
      logic               blk_fresh;                       // Block has fresh data
      logic [NCH*SEQ_W-1:0] seq_prev;                      // Last sequence counters
      logic               have_prev;                       // Seen a first commit
      logic [7:0]         err_cnt;                         // Frame sequence error count
      logic [15:0]        wd_time;                         // Watchdog time, ms
      logic [15:0]        wd_ms;                           // Elapsed ms
      logic [31:0]        wd_pre;                          // Tick prescaler
      logic               wd_exp;                          // Watchdog expired
      logic [DW-1:0]      dac;                             // Output codes
      logic               strobe;                          // Conversion pulse
      logic [31:0]        nbst;                            // Next block start time
      logic [7:0]         rdata;                           // Read data
   } osq_st_t;

   osq_st_t        st_r;                                   // State
   osq_st_t        st_nxt;                                 // Next state
   logic           f_valid;                                // FIFO has a vector
   logic [DW-1:0]  f_data;                                 // FIFO head
   logic           pop;                                    // Take FIFO head
   logic           sync1;                                  // Shifted block event
   logic           conv;                                   // Sample tick
   logic           match;                                  // Word count equals factor
   logic           seq_bad;                                // Sequence break seen
   logic [31:0]    per_clk;                                // Sample period in cycles
   logic signed [31:0] dly_clk;                            // Shift delay in cycles

   // True when any channel counter did not advance by exactly one
   function automatic logic seq_break(input logic [NCH*SEQ_W-1:0] prev, input logic [NCH*SEQ_W-1:0] cur);
      logic b;
      b = 1'b0;
      for (int c = 0; c < NCH; c++) begin
         if (cur[c*SEQ_W +: SEQ_W] != SEQ_W'(prev[c*SEQ_W +: SEQ_W] + 1'b1)) begin
            b = 1'b1;
         end
      end
      return b;
   endfunction

   // Samples wait here until their tick
   osq_fifo #(.W(DW), .DEPTH(FIFO_DEPTH)) u_fifo (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .in_valid  (pd_valid),
      .in_ready  (pd_ready),
      .in_data   (pd_data),
      .out_valid (f_valid),
      .out_ready (pop),
      .out_data  (f_data)
   );

   // Derived timing of the configuration
   always_comb begin
      per_clk = 32'(cfg.cycle_us) * 32'(US_CLK);
      if (cfg.factor != 8'h00) begin
         per_clk = per_clk / 32'(cfg.factor);
      end
      dly_clk = (32'(cfg.shift_us) + 32'(SHIFT_BIAS_US)) * 32'(US_CLK);
      match   = (cfg.word_count == cfg.factor);
      seq_bad = seq_break(st_r.seq_prev, pd_seq);
   end

   // Next state of the sequencer
   always_comb begin
      st_nxt        = st_r;
      st_nxt.strobe = 1'b0;
      pop           = 1'b0;
      sync1         = 1'b0;
      conv          = 1'b0;
      // Shift the block event; the sample ticks follow it
      if (sync1_raw) begin
         if (dly_clk <= 32'sd0) begin
            sync1 = 1'b1;
         end else begin
            st_nxt.dly_cnt  = dly_clk;
            st_nxt.dly_busy = 1'b1;
         end
      end else if (st_r.dly_busy) begin
         if (st_r.dly_cnt <= 32'd1) begin
            st_nxt.dly_busy = 1'b0;
            sync1           = 1'b1;
         end else begin
            st_nxt.dly_cnt = st_r.dly_cnt - 32'd1;
         end
      end
      // Block and tick sequencing
      if (sync1) begin
         st_nxt.blk       = OSQ_RUN;
         st_nxt.idx       = 8'h00;
         st_nxt.per_cnt   = per_clk;
         st_nxt.blk_fresh = st_r.fresh || pd_commit;
         st_nxt.nbst      = dc_time_lo + 32'(cfg.cycle_us) * 32'(US_NS);
         conv             = 1'b1;
      end else if (st_r.blk == OSQ_RUN) begin
         if (st_r.per_cnt > 32'd1) begin
            st_nxt.per_cnt = st_r.per_cnt - 32'd1;
         end else if (9'(st_r.idx) + 9'd1 < 9'(cfg.factor)) begin
            st_nxt.idx     = st_r.idx + 8'h01;
            st_nxt.per_cnt = per_clk;
            conv           = 1'b1;
         end else begin
            st_nxt.blk = OSQ_IDLE;
         end
      end
      // Fresh data flag, a commit in the block cycle wins
      if (pd_commit) begin
         st_nxt.fresh = 1'b1;
      end else if (sync1) begin
         st_nxt.fresh = 1'b0;
      end
      // Conversion on each tick unless the word count is wrong
      if (conv && match) begin
         st_nxt.strobe = 1'b1;
         if ((sync1 ? (st_r.fresh || pd_commit) : st_r.blk_fresh) && f_valid) begin
            st_nxt.dac = f_data;
            pop        = 1'b1;
         end
      end
      // Sequence counter monitoring
      if (pd_commit) begin
         st_nxt.have_prev = 1'b1;
         st_nxt.seq_prev  = pd_seq;
         if (st_r.have_prev && seq_bad) begin
            st_nxt.err_cnt = st_r.err_cnt + 8'h01;
         end
      end
      // Output watchdog
      if (wd_cfg_wr) begin
         st_nxt.wd_time = wd_cfg_ms;
      end
      if (pd_commit) begin
         st_nxt.wd_ms  = 16'h0000;
         st_nxt.wd_pre = 32'h0000_0000;
         st_nxt.wd_exp = 1'b0;
      end else if (st_r.wd_time == 16'h0000) begin
         st_nxt.wd_exp = 1'b0;
      end else if (!st_r.wd_exp) begin
         if (st_r.wd_pre >= 32'(MS_CYCLES - 1)) begin
            st_nxt.wd_pre = 32'h0000_0000;
            st_nxt.wd_ms  = st_r.wd_ms + 16'h0001;
            if (17'(st_r.wd_ms) + 17'd1 >= 17'(st_r.wd_time)) begin
               st_nxt.wd_exp = 1'b1;
            end
         end else begin
            st_nxt.wd_pre = st_r.wd_pre + 32'h0000_0001;
         end
      end
      if (st_nxt.wd_exp) begin
         st_nxt.dac = '0;
      end
      // Register read port, unmapped offsets read zero
      if (reg_rd) begin
         st_nxt.rdata = (reg_addr == REG_ERR_CNT_OFS) ? st_r.err_cnt : 8'h00;
      end
   end

   // State register
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st_r         <= '0;
         st_r.blk     <= OSQ_IDLE;
         st_r.err_cnt <= ERR_CNT_RST;
         st_r.wd_time <= WD_TIME_MS_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata             = st_r.rdata;
   assign dac_strobe            = st_r.strobe;
   assign dac_data              = st_r.dac;
   assign next_block_start_time = st_r.nbst;
   assign sample_index          = st_r.idx;
   assign wd_expired            = st_r.wd_exp;

   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   property p_block_start;
      sync1 |=> (st_r.blk == OSQ_RUN) && (sample_index == 8'h00);
   endproperty
   a_block_start: assert property (p_block_start) else $error("block did not start at index zero");

   property p_tick_period;
      conv |=> st_r.per_cnt == $past(per_clk);
   endproperty
   a_tick_period: assert property (p_tick_period) else $error("sample tick off its period");

   property p_conv_strobe;
      (conv && match) |=> dac_strobe;
   endproperty
   a_conv_strobe: assert property (p_conv_strobe) else $error("tick without conversion");

   property p_mismatch_quiet;
      !match |=> !dac_strobe;
   endproperty
   a_mismatch_quiet: assert property (p_mismatch_quiet) else $error("output despite count mismatch");

   property p_shift_origin;
      sync1 |-> (sync1_raw && dly_clk <= 32'sd0) || (!sync1_raw && st_r.dly_busy && st_r.dly_cnt <= 32'd1);
   endproperty
   a_shift_origin: assert property (p_shift_origin) else $error("block event not delayed by shift");

   property p_err_inc;
      (pd_commit && st_r.have_prev && seq_bad) |=> st_r.err_cnt == $past(st_r.err_cnt) + 8'h01;
   endproperty
   a_err_inc: assert property (p_err_inc) else $error("sequence break not counted");

   property p_wd_default;
      $rose(rst_n) |-> st_r.wd_time == WD_TIME_MS_RST;
   endproperty
   a_wd_default: assert property (p_wd_default) else $error("watchdog time wrong after reset");

   property p_wd_restart;
      pd_commit |=> !wd_expired && st_r.wd_ms == 16'h0000;
   endproperty
   a_wd_restart: assert property (p_wd_restart) else $error("commit did not restart watchdog");

   property p_hold_last;
      (conv && match && !st_nxt.wd_exp && !pop) |=> dac_data == $past(dac_data);
   endproperty
   a_hold_last: assert property (p_hold_last) else $error("output changed without fresh data");

   property p_wd_zero;
      wd_expired |-> dac_data == '0;
   endproperty
   a_wd_zero: assert property (p_wd_zero) else $error("expired watchdog left output nonzero");

   property p_wd_off;
      (st_r.wd_time == 16'h0000 && !wd_cfg_wr) |=> !wd_expired;
   endproperty
   a_wd_off: assert property (p_wd_off) else $error("disabled watchdog expired");

   property p_next_time;
      sync1 |=> next_block_start_time == $past(dc_time_lo) + 32'($past(cfg.cycle_us)) * 32'(US_NS);
   endproperty
   a_next_time: assert property (p_next_time) else $error("next block time wrong");

   property p_index_step;
      (conv && !sync1) |=> sample_index == $past(sample_index) + 8'h01;
   endproperty
   a_index_step: assert property (p_index_step) else $error("index did not advance");
endmodule

// File: verif/osq_master_model.sv
// Bus master model that feeds process data into the sequencer.
// Assumes the bench calls send_cycle once per bus cycle, after a clock edge.
`timescale 1ns/1ps

// ***************************************************************
// Master model
// ***************************************************************
module osq_master_model
   import osq_pkg::*;
#(
   parameter int NCH = 2                              // Output channels
) (
   input  wire logic                 mclk,            // Clock
   input  wire logic                 pd_ready,        // Room in the FIFO
   output logic                      pd_valid,        // Word offered
   output logic [NCH*SAMPLE_W-1:0]   pd_data,         // One sample per channel
   output logic                      pd_commit,       // Buffer access done
   output logic [NCH*SEQ_W-1:0]      pd_seq           // Sequence counters
);
   logic [SEQ_W-1:0] seq_r;                           // Last counter sent

   // Idle lines at time zero
   initial begin
      pd_valid  = 1'b0;
      pd_data   = '0;
      pd_commit = 1'b0;
      pd_seq    = '0;
      seq_r     = '0;
   end

   // Push n words, then commit with the counter moved on by step
   task automatic send_cycle(input int n, input logic [SAMPLE_W-1:0] base, input logic [SEQ_W-1:0] step);
      @(posedge mclk);
      for (int i = 0; i < n; i++) begin
         pd_valid <= 1'b1;
         pd_data  <= {NCH{base + SAMPLE_W'(i)}};
         @(posedge mclk);
         while (pd_ready !== 1'b1) @(posedge mclk);   // Hold until taken
      end
      pd_valid  <= 1'b0;
      pd_data   <= ~pd_data;                          // Released lines do not keep data
      seq_r      = seq_r + step;
      pd_commit <= 1'b1;
      pd_seq    <= {NCH{seq_r}};
      @(posedge mclk);
      pd_commit <= 1'b0;
      pd_seq    <= ~pd_seq;
   endtask
endmodule

// File: verif/oversampled_output_sequencer_test.sv
// Self-checking bench of the oversampled output sequencer.
// Assumes one 25 MHz clock and 10 cycles per watchdog millisecond tick.
`timescale 1ns/1ps

module oversampled_output_sequencer_test
   import osq_pkg::*;
;
   logic        mclk, rst_n, sync1_raw, wd_cfg_wr, reg_rd;   // Control inputs
   logic [31:0] dc_time_lo;                                  // Bus time
   osq_cfg_t    cfg;                                         // Block settings
   logic [15:0] wd_cfg_ms;                                   // Watchdog time
   logic [11:0] reg_addr;                                    // Register offset
   logic        pd_valid, pd_ready, pd_commit;               // Sample stream
   logic [31:0] pd_data, pd_seq, dac_data, next_block_start_time;
   logic [7:0]  reg_rdata, sample_index;                     // Read data, index
   logic        dac_strobe, wd_expired;                      // Conversion, expiry
   int          fails, cmp_count, cyc;                       // Counters

   // ***************************************************************
   // Design, master model and clock
   // ***************************************************************
   osq_sequencer #(.NCH(2), .MS_CYCLES(10)) dut (.mclk(mclk), .rst_n(rst_n), .sync1_raw(sync1_raw),
      .dc_time_lo(dc_time_lo), .cfg(cfg), .wd_cfg_wr(wd_cfg_wr), .wd_cfg_ms(wd_cfg_ms), .pd_valid(pd_valid),
      .pd_ready(pd_ready), .pd_data(pd_data), .pd_commit(pd_commit), .pd_seq(pd_seq), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_rdata(reg_rdata), .dac_strobe(dac_strobe), .dac_data(dac_data),
      .next_block_start_time(next_block_start_time), .sample_index(sample_index), .wd_expired(wd_expired));
   osq_master_model #(.NCH(2)) m (.mclk(mclk), .pd_ready(pd_ready), .pd_valid(pd_valid), .pd_data(pd_data),
      .pd_commit(pd_commit), .pd_seq(pd_seq));

   // 40 ns clock
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   // ***************************************************************
   // Tasks
   // ***************************************************************
   // Compare and count
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Print counts and verdict, then stop
   task automatic close_out;
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // Register read: strobe one cycle, data valid after it
   task automatic rd(input logic [11:0] a, output logic [7:0] d);
      @(posedge mclk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   // One-cycle raw block event
   task automatic fire;
      @(posedge mclk);
      sync1_raw <= 1'b1;
      @(posedge mclk);
      sync1_raw <= 1'b0;
   endtask

   // Cycles until the next conversion strobe, max+1 if none
   task automatic wait_strobe(input int max, output int n);
      for (n = 1; n <= max; n++) begin
         @(posedge mclk);
         #1;
         if (dac_strobe === 1'b1) break;
      end
   endtask

   // Timeout ceiling
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 12000) begin
         fails++;
         close_out;
      end
   end

   // ***************************************************************
   // Main sequence
   // ***************************************************************
   initial begin
      int n;
      logic [7:0]  d8;
      logic [31:0] hold;
      fails = 0;
      cmp_count = 0;
      cyc = 0;
      rst_n = 1'b0;
      sync1_raw = 1'b0;
      wd_cfg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 12'h000;
      wd_cfg_ms = 16'h0000;
      dc_time_lo = 32'h1234_5678;
      cfg = '{16'h0004, 8'h04, 8'h04, -16'sd20};          // Period 25 cycles, no delay
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      rd(REG_ERR_CNT_OFS, d8);
      chk(d8, 0);
      rd(12'h000, d8);
      chk(d8, 0);                                         // Unmapped offset reads zero
      // Fill the FIFO, first block outputs fresh data
      m.send_cycle(4, 16'h1000, 16'h0001);
      #1 chk(pd_ready, 0);
      fire;
      #1 chk(dac_strobe, 1);
      chk(sample_index, 0);
      chk(next_block_start_time, 32'h1234_5678 + 32'd4000);
      wait_strobe(40, n);
      chk(n, 25);
      chk(sample_index, 1);
      chk(dac_data[15:12], 4'h1);
      repeat (110) @(posedge mclk);
      // No commit since the last block: last word held
      hold = {2{16'h1003}};
      fire;
      #1 chk(dac_data, hold);
      wait_strobe(40, n);
      chk(dac_data, hold);
      repeat (110) @(posedge mclk);
      // Shift of one microsecond later delays by 25 cycles
      cfg.shift_us <= -16'sd19;
      fire;
      wait_strobe(60, n);
      chk(n, US_CLK);
      repeat (110) @(posedge mclk);
      cfg.shift_us <= -16'sd20;
      cfg.word_count <= 8'h03;
      fire;
      wait_strobe(30, n);
      chk(n, 31);
      @(posedge mclk);
      cfg.word_count <= 8'h04;
      // Consecutive, repeated and skipped counters
      m.send_cycle(1, 16'h2000, 16'h0001);
      rd(REG_ERR_CNT_OFS, d8);
      chk(d8, 0);
      m.send_cycle(1, 16'h2100, 16'h0000);
      rd(REG_ERR_CNT_OFS, d8);
      chk(d8, 1);
      m.send_cycle(1, 16'h2200, 16'h0002);
      rd(REG_ERR_CNT_OFS, d8);
      chk(d8, 2);
      // Default watchdog: 100 ticks of 10 cycles
      repeat (940) @(posedge mclk);
      #1 chk(wd_expired, 0);
      repeat (100) @(posedge mclk);
      #1 chk(wd_expired, 1);
      chk(dac_data, 0);
      m.send_cycle(1, 16'h2300, 16'h0001);
      @(posedge mclk);
      #1 chk(wd_expired, 0);
      // Watchdog time zero never expires
      @(posedge mclk);
      wd_cfg_wr <= 1'b1;
      wd_cfg_ms <= 16'h0000;
      @(posedge mclk);
      wd_cfg_wr <= 1'b0;
      repeat (1300) @(posedge mclk);
      #1 chk(wd_expired, 0);
      close_out;
   end
endmodule
